// *** ggc_pkg.sv ***
`default_nettype none
package ggc_pkg;
  localparam logic [4:0] GGC_DEVAD = 5'h07;
  localparam logic [15:0] GGC_CTRL_ADDR = 16'hFFE9;
  localparam int GGC_DATA_W = 16;
  // field positions inside the control word
  localparam int GGC_TM_HI = 15;
  localparam int GGC_TM_LO = 13;
  localparam int GGC_TM_TOP = 15;
  localparam int GGC_MAN_EN = 12;
  localparam int GGC_MAN_VAL = 11;
  localparam int GGC_PORT_TYPE = 10;
  localparam int GGC_ADV_FD = 9;
  localparam int GGC_ADV_HD = 8;
  localparam int GGC_RSVD_HI = 7;
  localparam int GGC_RSVD_LO = 0;
  localparam logic [7:0] GGC_RSVD_VALUE = 8'h00;
  localparam logic [2:0] GGC_TM_RESET = 3'h0;
  localparam logic [15:0] GGC_RDATA_IDLE = 16'h0000;
  // strap settle: two synchroniser stages before capture
  localparam logic [1:0] GGC_STRAP_SETTLE = 2'h2;
  localparam logic [1:0] GGC_CNT_STEP = 2'h1;
  localparam logic [1:0] GGC_CNT_ZERO = 2'h0;
  typedef enum logic [2:0] {
    GGC_TM_NORMAL = 3'h0,
    GGC_TM_WAVEFORM = 3'h1,
    GGC_TM_MASTER_JITTER = 3'h2,
    GGC_TM_SLAVE_JITTER = 3'h3,
    GGC_TM_DISTORTION = 3'h4
  } ggc_test_mode_t;
endpackage
`default_nettype wire

// *** ggc_control.sv ***
// Behaviour
// - decode test field: top bit set distortion, 011 slave jitter, 010 master, 001 waveform, 000 normal
// - test field reads back the last value written
// - bit 12 set forces manual role, clear resolves automatically; reads back
// - bit 11 sets manual role, one master zero slave; reads back last write
// - bit 10 advertises repeater when one, DTE when zero; reads back
// - automatic: repeater facing DTE becomes master, DTE facing repeater becomes slave, otherwise seed decides
// - bit 9 offers full-duplex capability when set; reads back
// - bit 8 offers half-duplex capability when set; reads back
`default_nettype none
module ggc_control (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic [4:0] mgmt_devad_i,
  input wire logic [15:0] mgmt_addr_i,
  input wire logic [ggc_pkg::GGC_DATA_W-1:0] mgmt_wdata_i,
  input wire logic mgmt_write_i,
  input wire logic mgmt_read_i,
  input wire logic strap_manual_role_select_i,
  input wire logic strap_switch_port_type_i,
  input wire logic strap_advertise_half_duplex_i,
  input wire logic strap_negotiated_speed_set_i,
  input wire logic partner_repeater_i,
  input wire logic seed_master_i,
  output logic [ggc_pkg::GGC_DATA_W-1:0] mgmt_rdata_o,
  output logic mgmt_rvalid_o,
  output logic straps_loaded_o,
  output ggc_pkg::ggc_test_mode_t test_mode_o,
  output logic manual_role_o,
  output logic role_master_o,
  output logic adv_repeater_o,
  output logic adv_full_duplex_o,
  output logic adv_half_duplex_o
);
  import ggc_pkg::*;

  logic [3:0] strap_meta_reg;
  logic [3:0] strap_sync_reg;
  logic [1:0] settle_cnt_reg;
  logic loaded_reg;
  logic load_pulse;
  logic hit;
  logic wr_hit;
  logic [2:0] tm_reg;
  logic man_en_reg;
  logic man_val_reg;
  logic port_type_reg;
  logic adv_fd_reg;
  logic adv_hd_reg;
  logic [GGC_DATA_W-1:0] ctrl_word;
  logic role_master_next;
  ggc_test_mode_t test_mode_next;

  // strap pins cross in through two stages
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      strap_meta_reg <= 4'h0;
      strap_sync_reg <= 4'h0;
    end else begin
      strap_meta_reg <= {strap_negotiated_speed_set_i, strap_advertise_half_duplex_i,
                         strap_switch_port_type_i, strap_manual_role_select_i};
      strap_sync_reg <= strap_meta_reg;
    end
  end

  // wait for the synchroniser to fill, then capture once
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      settle_cnt_reg <= GGC_CNT_ZERO;
      loaded_reg <= 1'b0;
    end else begin
      if (settle_cnt_reg != GGC_STRAP_SETTLE) begin
        settle_cnt_reg <= settle_cnt_reg + GGC_CNT_STEP;
      end
      if (load_pulse) begin
        loaded_reg <= 1'b1;
      end
    end
  end

  assign load_pulse = (settle_cnt_reg == GGC_STRAP_SETTLE) && !loaded_reg;
  assign hit = (mgmt_devad_i == GGC_DEVAD) && (mgmt_addr_i == GGC_CTRL_ADDR);
  // writes before the strap capture are dropped
  assign wr_hit = mgmt_write_i && hit && loaded_reg;

  // test mode field, plain storage
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tm_reg <= GGC_TM_RESET;
    end else if (wr_hit) begin
      tm_reg <= mgmt_wdata_i[GGC_TM_HI:GGC_TM_LO];
    end
  end

  // strap-defaulted fields
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      man_en_reg <= 1'b0;
      man_val_reg <= 1'b0;
      port_type_reg <= 1'b0;
      adv_fd_reg <= 1'b0;
      adv_hd_reg <= 1'b0;
    end else if (load_pulse) begin
      man_en_reg <= strap_sync_reg[0];
      man_val_reg <= strap_sync_reg[1];
      port_type_reg <= strap_sync_reg[1];
      adv_fd_reg <= strap_sync_reg[3];
      adv_hd_reg <= strap_sync_reg[2] & strap_sync_reg[3];
    end else if (wr_hit) begin
      man_en_reg <= mgmt_wdata_i[GGC_MAN_EN];
      man_val_reg <= mgmt_wdata_i[GGC_MAN_VAL];
      port_type_reg <= mgmt_wdata_i[GGC_PORT_TYPE];
      adv_fd_reg <= mgmt_wdata_i[GGC_ADV_FD];
      adv_hd_reg <= mgmt_wdata_i[GGC_ADV_HD];
    end
  end

  // read image, reserved low byte fixed
  assign ctrl_word = {tm_reg, man_en_reg, man_val_reg, port_type_reg, adv_fd_reg,
                      adv_hd_reg, GGC_RSVD_VALUE};

  // read answer one cycle after the request; unmapped reads give zero
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mgmt_rdata_o <= GGC_RDATA_IDLE;
      mgmt_rvalid_o <= 1'b0;
    end else begin
      mgmt_rvalid_o <= mgmt_read_i;
      mgmt_rdata_o <= (mgmt_read_i && hit) ? ctrl_word : GGC_RDATA_IDLE;
    end
  end

  // test mode decode
  always_comb begin
    test_mode_next = GGC_TM_NORMAL;
    if (tm_reg[GGC_TM_TOP - GGC_TM_LO]) begin
      test_mode_next = GGC_TM_DISTORTION;
    end else begin
      case (tm_reg)
        3'h3: test_mode_next = GGC_TM_SLAVE_JITTER;
        3'h2: test_mode_next = GGC_TM_MASTER_JITTER;
        3'h1: test_mode_next = GGC_TM_WAVEFORM;
        default: test_mode_next = GGC_TM_NORMAL;
      endcase
    end
  end

  // role resolution: manual, else port type, else seed outcome
  always_comb begin
    role_master_next = seed_master_i;
    if (man_en_reg) begin
      role_master_next = man_val_reg;
    end else if (port_type_reg && !partner_repeater_i) begin
      role_master_next = 1'b1;
    end else if (!port_type_reg && partner_repeater_i) begin
      role_master_next = 1'b0;
    end
  end

  // registered outputs toward the negotiation engine
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      test_mode_o <= GGC_TM_NORMAL;
      manual_role_o <= 1'b0;
      role_master_o <= 1'b0;
      adv_repeater_o <= 1'b0;
      adv_full_duplex_o <= 1'b0;
      adv_half_duplex_o <= 1'b0;
      straps_loaded_o <= 1'b0;
    end else begin
      test_mode_o <= test_mode_next;
      manual_role_o <= man_en_reg;
      role_master_o <= role_master_next;
      adv_repeater_o <= port_type_reg;
      adv_full_duplex_o <= adv_fd_reg;
      adv_half_duplex_o <= adv_hd_reg;
      straps_loaded_o <= loaded_reg;
    end
  end

  // checks
  property p_tm_distortion;
    @(posedge clock_i) disable iff (!reset_n_i)
      tm_reg[GGC_TM_TOP - GGC_TM_LO] |=> test_mode_o == GGC_TM_DISTORTION;
  endproperty
  a_tm_distortion: assert property (p_tm_distortion) else $error("distortion decode wrong");

  property p_tm_low;
    @(posedge clock_i) disable iff (!reset_n_i)
      !tm_reg[GGC_TM_TOP - GGC_TM_LO] |=> test_mode_o == ggc_test_mode_t'($past(tm_reg));
  endproperty
  a_tm_low: assert property (p_tm_low) else $error("low test mode decode wrong");

  property p_tm_readback;
    @(posedge clock_i) disable iff (!reset_n_i)
      wr_hit ##1 (mgmt_read_i && hit && !mgmt_write_i)
        |=> mgmt_rvalid_o
          && mgmt_rdata_o[GGC_TM_HI:GGC_TM_LO] == $past(mgmt_wdata_i[GGC_TM_HI:GGC_TM_LO], 2);
  endproperty
  a_tm_readback: assert property (p_tm_readback) else $error("test field readback wrong");

  property p_manual_role;
    @(posedge clock_i) disable iff (!reset_n_i)
      man_en_reg |=> role_master_o == $past(man_val_reg);
  endproperty
  a_manual_role: assert property (p_manual_role) else $error("manual role not applied");

  property p_man_val_write;
    @(posedge clock_i) disable iff (!reset_n_i)
      wr_hit |=> man_val_reg == $past(mgmt_wdata_i[GGC_MAN_VAL])
        ##1 manual_role_o == $past(man_en_reg);
  endproperty
  a_man_val_write: assert property (p_man_val_write) else $error("manual value not stored");

  property p_port_type;
    @(posedge clock_i) disable iff (!reset_n_i)
      wr_hit |-> ##2 adv_repeater_o == $past(mgmt_wdata_i[GGC_PORT_TYPE], 2);
  endproperty
  a_port_type: assert property (p_port_type) else $error("port type not advertised");

  property p_auto_master;
    @(posedge clock_i) disable iff (!reset_n_i)
      (!man_en_reg && port_type_reg && !partner_repeater_i) |=> role_master_o;
  endproperty
  a_auto_master: assert property (p_auto_master) else $error("repeater did not win master");

  property p_auto_seed;
    @(posedge clock_i) disable iff (!reset_n_i)
      (!man_en_reg && port_type_reg == partner_repeater_i) |=> role_master_o == $past(seed_master_i);
  endproperty
  a_auto_seed: assert property (p_auto_seed) else $error("port type influenced tie");

  property p_adv_fd;
    @(posedge clock_i) disable iff (!reset_n_i)
      wr_hit |-> ##2 adv_full_duplex_o == $past(mgmt_wdata_i[GGC_ADV_FD], 2);
  endproperty
  a_adv_fd: assert property (p_adv_fd) else $error("full duplex advert wrong");

  property p_adv_hd;
    @(posedge clock_i) disable iff (!reset_n_i)
      wr_hit |-> ##2 adv_half_duplex_o == $past(mgmt_wdata_i[GGC_ADV_HD], 2);
  endproperty
  a_adv_hd: assert property (p_adv_hd) else $error("half duplex advert wrong");

  property p_rsvd_zero;
    @(posedge clock_i) disable iff (!reset_n_i)
      mgmt_rvalid_o |-> mgmt_rdata_o[GGC_RSVD_HI:GGC_RSVD_LO] == GGC_RSVD_VALUE;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits not zero");

  property p_strap_load;
    @(posedge clock_i) disable iff (!reset_n_i)
      load_pulse |=> man_en_reg == $past(strap_sync_reg[0])
        && adv_hd_reg == ($past(strap_sync_reg[2]) & $past(strap_sync_reg[3]));
  endproperty
  a_strap_load: assert property (p_strap_load) else $error("straps not captured");

  c_strap_load: cover property (@(posedge clock_i) disable iff (!reset_n_i) load_pulse);
  c_tm_write: cover property (@(posedge clock_i) disable iff (!reset_n_i)
    wr_hit && mgmt_wdata_i[GGC_TM_TOP]);
  c_auto_master: cover property (@(posedge clock_i) disable iff (!reset_n_i)
    !man_en_reg && port_type_reg && !partner_repeater_i);
  c_read: cover property (@(posedge clock_i) disable iff (!reset_n_i) mgmt_read_i && hit);
endmodule
`default_nettype wire

// *** gigabit_copper_control_register_bench.sv ***
`default_nettype none
module gigabit_copper_control_register_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import ggc_pkg::*;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [4:0] devad = GGC_DEVAD;
  logic [15:0] addr = GGC_CTRL_ADDR;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] strap = 4'h0; // manual, switch, half, speed
  logic prep = 1'b0;
  logic seed = 1'b0;
  logic [15:0] rdata;
  logic rvalid, loaded, man, master, rep, fd, hd;
  ggc_test_mode_t tm;
  int n_fail = 0;
  int n_compared = 0;
  int cycles = 0;

  ggc_control i_dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .mgmt_devad_i(devad),
    .mgmt_addr_i(addr), .mgmt_wdata_i(wdata), .mgmt_write_i(wr), .mgmt_read_i(rd),
    .strap_manual_role_select_i(strap[3]), .strap_switch_port_type_i(strap[2]),
    .strap_advertise_half_duplex_i(strap[1]), .strap_negotiated_speed_set_i(strap[0]),
    .partner_repeater_i(prep), .seed_master_i(seed), .mgmt_rdata_o(rdata),
    .mgmt_rvalid_o(rvalid), .straps_loaded_o(loaded), .test_mode_o(tm),
    .manual_role_o(man), .role_master_o(master), .adv_repeater_o(rep),
    .adv_full_duplex_o(fd), .adv_half_duplex_o(hd));

  // clock and hang guard
  always #50 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      stop_test();
    end
  end

  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic wait_n(int n);
    repeat (n) @(negedge clock_i);
  endtask

  // one-cycle write strobe, then let fields and outputs land
  task automatic write_reg(logic [15:0] d);
    @(negedge clock_i);
    wdata = d;
    wr = 1'b1;
    @(negedge clock_i);
    wr = 1'b0;
    wait_n(2);
  endtask

  // read answered one cycle later, for one cycle only
  task automatic read_check(string name, logic [15:0] exp);
    @(negedge clock_i);
    rd = 1'b1;
    @(negedge clock_i);
    rd = 1'b0;
    check("rvalid", {15'h0, rvalid}, 16'h0001);
    check(name, rdata, exp);
    @(negedge clock_i);
    check("rvalid_drop", {15'h0, rvalid}, 16'h0000);
  endtask

  // output copies of bits 12, 10, 9, 8
  task automatic check_fields(logic [15:0] e);
    check("field_outputs", {12'h0, man, rep, fd, hd}, {12'h0, e[12], e[10], e[9], e[8]});
  endtask

  task automatic t_straps(logic [3:0] s, logic [15:0] e);
    reset_n_i = 1'b0;
    strap = s;
    wait_n(20);
    reset_n_i = 1'b1;
    wait_n(6);
    check("straps_loaded", {15'h0, loaded}, 16'h0001);
    read_check("strap_word", e);
    check_fields(e);
    check("tm_reset", 16'(tm), 16'h0000);
  endtask

  task automatic t_test_mode();
    logic [2:0] m;
    for (int i = 0; i < 8; i++) begin
      m = 3'(i);
      write_reg({m, 13'h0000});
      check("test_mode", 16'(tm), m[2] ? 16'h0004 : 16'(m));
      read_check("tm_read", {m, 13'h0000});
    end
  endtask

  task automatic t_manual();
    write_reg(16'h1800);
    check("manual_master", {15'h0, master}, 16'h0001);
    read_check("manual_read", 16'h1800);
    write_reg(16'h1000);
    check("manual_slave", {15'h0, master}, 16'h0000);
    check_fields(16'h1000);
  endtask

  task automatic t_auto();
    logic e;
    for (int k = 0; k < 8; k++) begin
      write_reg({5'h00, k[2], 10'h000});
      prep = k[1];
      seed = k[0];
      wait_n(2);
      e = (k[2] && !k[1]) ? 1'b1 : ((!k[2] && k[1]) ? 1'b0 : k[0]);
      check("auto_role", {15'h0, master}, {15'h0, e});
      check_fields({5'h00, k[2], 10'h000});
    end
  endtask

  // write and read on consecutive edges, read must see the new field
  task automatic t_back_to_back();
    @(negedge clock_i);
    wdata = 16'hA300;
    wr = 1'b1;
    @(negedge clock_i);
    wr = 1'b0;
    rd = 1'b1;
    @(negedge clock_i);
    rd = 1'b0;
    check("b2b_rvalid", {15'h0, rvalid}, 16'h0001);
    check("b2b_read", rdata, 16'hA300);
    wait_n(2);
    check("b2b_mode", 16'(tm), 16'h0004);
  endtask

  task automatic t_reserved();
    write_reg(16'h03FF);
    read_check("reserved_read", 16'h0300);
    check_fields(16'h0300);
    addr = 16'hFFEA;
    write_reg(16'h1400);
    read_check("unmapped_read", 16'h0000);
    addr = GGC_CTRL_ADDR;
    devad = 5'h01;
    write_reg(16'h1400);
    devad = GGC_DEVAD;
    read_check("misdirected_write", 16'h0300);
  endtask

  initial begin
    t_straps(4'h5, 16'h0E00);
    t_test_mode();
    t_manual();
    t_auto();
    t_back_to_back();
    t_reserved();
    t_straps(4'hB, 16'h1300);
    stop_test();
  end
endmodule
`default_nettype wire
